// File: adc_cfg_pkg.sv
package adc_cfg_pkg;

  // ------------------------------------------------------------
  // Word layout
  // ------------------------------------------------------------
  localparam int CFG_W         = 24;
  localparam int CMD_W         = 8;
  localparam int CNT_W         = 5;
  localparam int CHOP_HI       = 21;
  localparam int CHOP_LO       = 20;
  localparam int MULTI_BIT     = 18;
  localparam int LOOP_BIT      = 17;
  localparam int WAIT_BIT      = 16;
  localparam int DEPTH_HI      = 15;
  localparam int DEPTH_LO      = 12;
  localparam int PSS_BIT       = 11;
  localparam int PUMP_DIS_BIT  = 10;
  localparam int PS_RUN_BIT    = 9;
  localparam int LOW_PWR_BIT   = 8;
  localparam int SOFT_RST_BIT  = 7;
  localparam int RST_VALID_BIT = 6;
  localparam int OSC_DET_BIT   = 5;
  localparam int OVR_BIT       = 4;

  localparam logic [CFG_W-1:0] CFG_RESET   = 24'h000000;
  localparam logic [CFG_W-1:0] CFG_WR_MASK = 24'h37FF80;

  // ------------------------------------------------------------
  // Command byte
  // ------------------------------------------------------------
  localparam int CMD_START_BIT = 7;
  localparam int PTR_HI        = 6;
  localparam int PTR_LO        = 3;
  localparam int CC_HI         = 2;
  localparam logic [2:0]       CC_CONVERT  = 3'h0;
  localparam logic [CMD_W-1:0] CMD_WR_CFG  = 8'h03;
  localparam logic [CMD_W-1:0] CMD_RD_CFG  = 8'h0B;
  localparam logic [CNT_W-1:0] CNT_CMD_END = 5'h07;
  localparam logic [CNT_W-1:0] CNT_FRM_END = 5'h1F;

  // ------------------------------------------------------------
  // Chop rates in Hz
  // ------------------------------------------------------------
  localparam logic [1:0]  CHOP_CODE_256   = 2'h0;
  localparam logic [1:0]  CHOP_CODE_4096  = 2'h1;
  localparam logic [1:0]  CHOP_CODE_16384 = 2'h2;
  localparam logic [14:0] CHOP_HZ_256     = 15'h0100;
  localparam logic [14:0] CHOP_HZ_4096    = 15'h1000;
  localparam logic [14:0] CHOP_HZ_16384   = 15'h4000;
  localparam logic [14:0] CHOP_HZ_1024    = 15'h0400;

  // ------------------------------------------------------------
  // Sequencer
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    SQ_IDLE = 2'b00,
    SQ_CONV = 2'b01,
    SQ_WAIT = 2'b11
  } seq_state_e;

  localparam int PUMP_DIV_DEF = 16;

endpackage

// File: serial_frame_port.sv
`timescale 1ns/1ps
module serial_frame_port
  import adc_cfg_pkg::*;
(
  // Link
  input  wire logic             i_sclk,
  input  wire logic             i_rst_n,
  input  wire logic             i_cs_n,
  input  wire logic             i_sdi,
  output logic                  o_sdo,
  output logic                  o_sdo_oe,
  // Events toward core
  output logic                  o_wr_tog,
  output logic [CFG_W-1:0]      o_wr_word,
  output logic                  o_rd_tog,
  output logic                  o_start_tog,
  output logic [CMD_W-1:0]      o_start_cmd,
  // Read image from core
  input  wire logic             i_img_tog,
  input  wire logic [CFG_W-1:0] i_img_word,
  output logic                  o_img_ack
);

  logic [CNT_W-1:0] cnt_r;
  logic [CFG_W-1:0] in_sh_r;
  logic [CFG_W-1:0] out_sh_r;
  logic [CFG_W-1:0] img_r;
  logic             rd_phase_r;
  logic             wr_phase_r;
  logic             img_s1_r;
  logic             img_s2_r;
  logic [CMD_W-1:0] cmd;

  assign cmd = {in_sh_r[CMD_W-2:0], i_sdi};

  // ------------------------------------------------------------
  // Read image handshake
  // ------------------------------------------------------------
  always_ff @(posedge i_sclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      img_s1_r  <= 1'b0;
      img_s2_r  <= 1'b0;
      o_img_ack <= 1'b0;
      img_r     <= CFG_RESET;
    end else begin
      img_s1_r <= i_img_tog;
      img_s2_r <= img_s1_r;
      if (img_s2_r != o_img_ack) begin
        img_r     <= i_img_word;
        o_img_ack <= img_s2_r;
      end
    end
  end

  // ------------------------------------------------------------
  // Frame engine
  // ------------------------------------------------------------
  always_ff @(posedge i_sclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cnt_r       <= '0;
      in_sh_r     <= '0;
      out_sh_r    <= '0;
      rd_phase_r  <= 1'b0;
      wr_phase_r  <= 1'b0;
      o_sdo       <= 1'b0;
      o_sdo_oe    <= 1'b0;
      o_wr_tog    <= 1'b0;
      o_wr_word   <= CFG_RESET;
      o_rd_tog    <= 1'b0;
      o_start_tog <= 1'b0;
      o_start_cmd <= '0;
    end else if (i_cs_n) begin
      cnt_r      <= '0;
      rd_phase_r <= 1'b0;
      wr_phase_r <= 1'b0;
      o_sdo_oe   <= 1'b0;
    end else begin
      in_sh_r  <= {in_sh_r[CFG_W-2:0], i_sdi};
      out_sh_r <= {out_sh_r[CFG_W-2:0], 1'b0};
      o_sdo    <= out_sh_r[CFG_W-1];
      cnt_r    <= cnt_r + 5'h01;
      if (cnt_r == CNT_CMD_END) begin
        if (cmd[CMD_START_BIT]) begin
          o_start_tog <= ~o_start_tog;
          o_start_cmd <= cmd;
          cnt_r       <= '0;
        end else if (cmd == CMD_RD_CFG) begin
          rd_phase_r <= 1'b1;
          o_sdo_oe   <= 1'b1;
          o_sdo      <= img_r[CFG_W-1];
          out_sh_r   <= {img_r[CFG_W-2:0], 1'b0};
        end else if (cmd == CMD_WR_CFG) begin
          wr_phase_r <= 1'b1;
        end else begin
          cnt_r <= '0;
        end
      end else if (cnt_r == CNT_FRM_END) begin
        cnt_r      <= '0;
        rd_phase_r <= 1'b0;
        wr_phase_r <= 1'b0;
        o_sdo_oe   <= 1'b0;
        if (rd_phase_r) begin
          o_rd_tog <= ~o_rd_tog;
        end
        if (wr_phase_r) begin
          o_wr_word <= {in_sh_r[CFG_W-2:0], i_sdi};
          o_wr_tog  <= ~o_wr_tog;
        end
      end
    end
  end

endmodule // serial_frame_port

// File: adc_cfg_core.sv
`timescale 1ns/1ps
module adc_cfg_core
  import adc_cfg_pkg::*;
#(
  parameter int PUMP_DIV = PUMP_DIV_DEF
) (
  // Clocks and reset
  input  wire logic        i_core_clk,
  input  wire logic        i_rst_n,
  input  wire logic        i_sclk,
  // Serial port
  input  wire logic        i_cs_n,
  input  wire logic        i_sdi,
  output logic             o_sdo,
  output logic             o_sdo_oe,
  // Conversion engine
  input  wire logic        i_conv_done,
  input  wire logic        i_results_read,
  input  wire logic        i_stop_conv,
  output logic             o_conv_go,
  output logic             o_cal_go,
  output logic [2:0]       o_cal_code,
  output logic [3:0]       o_conv_chan,
  output logic             o_set_done,
  output logic             o_busy,
  output logic [4:0]       o_csr_count,
  // Analog status pins
  input  wire logic        i_osc_detect,
  input  wire logic        i_overrange,
  // Analog controls
  output logic [14:0]      o_chop_freq_hz,
  output logic             o_standby,
  output logic             o_sleep,
  output logic             o_osc_enable,
  output logic             o_low_power,
  output logic             o_sys_reset,
  output logic             o_pump_o,
  output logic             o_pump_oe
);

  // ------------------------------------------------------------
  // Link side
  // ------------------------------------------------------------
  logic             wr_tog;
  logic [CFG_W-1:0] wr_word;
  logic             rd_tog;
  logic             start_tog;
  logic [CMD_W-1:0] start_cmd;
  logic             img_ack;
  logic             img_tog_r;
  logic [CFG_W-1:0] img_word_r;

  serial_frame_port u_port (
    .i_sclk      (i_sclk),
    .i_rst_n     (i_rst_n),
    .i_cs_n      (i_cs_n),
    .i_sdi       (i_sdi),
    .o_sdo       (o_sdo),
    .o_sdo_oe    (o_sdo_oe),
    .o_wr_tog    (wr_tog),
    .o_wr_word   (wr_word),
    .o_rd_tog    (rd_tog),
    .o_start_tog (start_tog),
    .o_start_cmd (start_cmd),
    .i_img_tog   (img_tog_r),
    .i_img_word  (img_word_r),
    .o_img_ack   (img_ack)
  );

  // ------------------------------------------------------------
  // Synchronisers: toggles get a third stage for edges
  // ------------------------------------------------------------
  localparam int NSYNC = 6;
  logic [NSYNC-1:0] sync_in;
  logic [NSYNC-1:0] s1_r;
  logic [NSYNC-1:0] s2_r;
  logic [NSYNC-1:0] s3_r;
  logic             wr_pls;
  logic             rd_pls;
  logic             start_pls;
  logic             ack_lvl;
  logic             osc_lvl;
  logic             ovr_lvl;

  assign sync_in = {i_overrange, i_osc_detect, img_ack, start_tog, rd_tog, wr_tog};

  genvar g;
  generate
    for (g = 0; g < NSYNC; g++) begin : g_sync
      always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
          s1_r[g] <= 1'b0;
          s2_r[g] <= 1'b0;
          s3_r[g] <= 1'b0;
        end else begin
          s1_r[g] <= sync_in[g];
          s2_r[g] <= s1_r[g];
          s3_r[g] <= s2_r[g];
        end
      end
    end
  endgenerate

  assign wr_pls    = s2_r[0] ^ s3_r[0];
  assign rd_pls    = s2_r[1] ^ s3_r[1];
  assign start_pls = s2_r[2] ^ s3_r[2];
  assign ack_lvl   = s2_r[3];
  assign osc_lvl   = s2_r[4];
  assign ovr_lvl   = s2_r[5];

  // ------------------------------------------------------------
  // Configuration register
  // ------------------------------------------------------------
  logic [CFG_W-1:0] cfg_r;
  logic             rv_r;
  logic             od_r;
  logic             of_r;
  logic             rs_prev_r;
  logic [CFG_W-1:0] img_nxt;
  logic [1:0]       chop_sel;
  logic [3:0]       depth;
  logic             rs_fall;

  assign chop_sel = cfg_r[CHOP_HI:CHOP_LO];
  assign depth    = cfg_r[DEPTH_HI:DEPTH_LO];
  assign rs_fall  = rs_prev_r & ~cfg_r[SOFT_RST_BIT];

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cfg_r <= CFG_RESET;
    end else if (wr_pls) begin
      cfg_r <= wr_word & CFG_WR_MASK;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rv_r      <= 1'b0;
      rs_prev_r <= 1'b0;
      od_r      <= 1'b0;
      of_r      <= 1'b0;
    end else begin
      rs_prev_r <= cfg_r[SOFT_RST_BIT];
      od_r      <= osc_lvl;
      of_r      <= ovr_lvl;
      if (rs_fall) begin
        rv_r <= 1'b1;
      end else if (rd_pls) begin
        rv_r <= 1'b0;
      end
    end
  end

  always_comb begin
    img_nxt                = cfg_r;
    img_nxt[RST_VALID_BIT] = rv_r;
    img_nxt[OSC_DET_BIT]   = od_r;
    img_nxt[OVR_BIT]       = of_r;
  end

  // Publish read image; one word in flight until acknowledged
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      img_tog_r  <= 1'b0;
      img_word_r <= CFG_RESET;
    end else if (ack_lvl == img_tog_r && img_nxt != img_word_r) begin
      img_word_r <= img_nxt;
      img_tog_r  <= ~img_tog_r;
    end
  end

  // ------------------------------------------------------------
  // Analog controls
  // ------------------------------------------------------------
  logic [$clog2(PUMP_DIV+1)-1:0] pump_cnt_r;
  logic                          saving;

  assign saving = cfg_r[PS_RUN_BIT];

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_chop_freq_hz <= CHOP_HZ_256;
      o_standby      <= 1'b0;
      o_sleep        <= 1'b0;
      o_osc_enable   <= 1'b1;
      o_low_power    <= 1'b0;
      o_sys_reset    <= 1'b0;
      o_csr_count    <= 5'h01;
    end else begin
      unique case (chop_sel)
        CHOP_CODE_256:   o_chop_freq_hz <= CHOP_HZ_256;
        CHOP_CODE_4096:  o_chop_freq_hz <= CHOP_HZ_4096;
        CHOP_CODE_16384: o_chop_freq_hz <= CHOP_HZ_16384;
        default:         o_chop_freq_hz <= CHOP_HZ_1024;
      endcase
      o_standby    <= saving & ~cfg_r[PSS_BIT];
      o_sleep      <= saving & cfg_r[PSS_BIT];
      o_osc_enable <= ~(saving & cfg_r[PSS_BIT]);
      o_low_power  <= cfg_r[LOW_PWR_BIT];
      o_sys_reset  <= cfg_r[SOFT_RST_BIT];
      o_csr_count  <= {1'b0, depth} + 5'h01;
    end
  end

  // Pump drive stops in sleep since the oscillator is off
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pump_cnt_r <= '0;
      o_pump_o   <= 1'b0;
      o_pump_oe  <= 1'b1;
    end else begin
      o_pump_oe <= ~cfg_r[PUMP_DIS_BIT];
      if (cfg_r[PUMP_DIS_BIT] || o_sleep) begin
        pump_cnt_r <= '0;
        o_pump_o   <= 1'b0;
      end else if (pump_cnt_r == ($bits(pump_cnt_r))'(PUMP_DIV - 1)) begin
        pump_cnt_r <= '0;
        o_pump_o   <= ~o_pump_o;
      end else begin
        pump_cnt_r <= pump_cnt_r + 1'b1;
      end
    end
  end

  // ------------------------------------------------------------
  // Conversion sequencer
  // ------------------------------------------------------------
  seq_state_e state_r;
  logic [4:0] n_r;
  logic [3:0] idx_r;
  logic [3:0] ptr_r;
  logic       loop_r;
  logic       wait_r;
  logic       cal_r;
  logic       multi_r;
  logic       is_cal;
  logic       last;
  logic       abort;

  assign is_cal = start_cmd[CC_HI:0] != CC_CONVERT;
  assign last   = ({1'b0, idx_r} + 5'h01) == n_r;
  assign abort  = i_stop_conv | cfg_r[SOFT_RST_BIT];

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_r     <= SQ_IDLE;
      n_r         <= 5'h01;
      idx_r       <= '0;
      ptr_r       <= '0;
      loop_r      <= 1'b0;
      wait_r      <= 1'b0;
      cal_r       <= 1'b0;
      multi_r     <= 1'b0;
      o_conv_go   <= 1'b0;
      o_cal_go    <= 1'b0;
      o_cal_code  <= '0;
      o_conv_chan <= '0;
      o_set_done  <= 1'b0;
      o_busy      <= 1'b0;
    end else begin
      o_conv_go  <= 1'b0;
      o_cal_go   <= 1'b0;
      o_set_done <= 1'b0;
      unique case (state_r)
        SQ_IDLE: begin
          if (start_pls && !cfg_r[SOFT_RST_BIT]) begin
            state_r    <= SQ_CONV;
            o_busy     <= 1'b1;
            idx_r      <= '0;
            ptr_r      <= start_cmd[PTR_HI:PTR_LO];
            cal_r      <= is_cal;
            o_cal_code <= start_cmd[CC_HI:0];
            if (is_cal) begin
              n_r         <= 5'h01;
              loop_r      <= 1'b0;
              wait_r      <= 1'b0;
              multi_r     <= 1'b0;
              o_cal_go    <= 1'b1;
              o_conv_chan <= start_cmd[PTR_HI:PTR_LO];
            end else begin
              multi_r     <= cfg_r[MULTI_BIT];
              n_r         <= cfg_r[MULTI_BIT] ? {1'b0, depth} + 5'h01 : 5'h01;
              loop_r      <= cfg_r[LOOP_BIT];
              wait_r      <= cfg_r[LOOP_BIT] & cfg_r[WAIT_BIT];
              o_conv_go   <= 1'b1;
              o_conv_chan <= cfg_r[MULTI_BIT] ? 4'h0 : start_cmd[PTR_HI:PTR_LO];
            end
          end
        end
        SQ_CONV: begin
          if (abort) begin
            state_r <= SQ_IDLE;
            o_busy  <= 1'b0;
          end else if (i_conv_done) begin
            if (!last) begin
              idx_r       <= idx_r + 4'h1;
              o_conv_go   <= 1'b1;
              o_conv_chan <= idx_r + 4'h1;
            end else begin
              o_set_done <= 1'b1;
              idx_r      <= '0;
              if (!loop_r) begin
                state_r <= SQ_IDLE;
                o_busy  <= 1'b0;
              end else if (wait_r) begin
                state_r <= SQ_WAIT;
              end else begin
                o_conv_go   <= 1'b1;
                o_conv_chan <= multi_r ? 4'h0 : ptr_r;
              end
            end
          end
        end
        SQ_WAIT: begin
          if (abort) begin
            state_r <= SQ_IDLE;
            o_busy  <= 1'b0;
          end else if (i_results_read) begin
            state_r     <= SQ_CONV;
            o_conv_go   <= 1'b1;
            o_conv_chan <= multi_r ? 4'h0 : ptr_r;
          end
        end
        default: begin
          state_r <= SQ_IDLE;
          o_busy  <= 1'b0;
        end
      endcase
    end
  end

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  sequence s_conv_start;
    state_r == SQ_IDLE && start_pls && !cfg_r[SOFT_RST_BIT] && !is_cal;
  endsequence

  sequence s_cal_start;
    state_r == SQ_IDLE && start_pls && !cfg_r[SOFT_RST_BIT] && is_cal;
  endsequence

  property p_chop_16k;
    @(posedge i_core_clk) disable iff (!i_rst_n)
      chop_sel == CHOP_CODE_16384 |=> o_chop_freq_hz == CHOP_HZ_16384;
  endproperty
  a_chop_16k: assert property (p_chop_16k) else $error("chop rate wrong");

  property p_single;
    @(posedge i_core_clk) disable iff (!i_rst_n)
      s_conv_start and !cfg_r[MULTI_BIT] |=> o_conv_go && n_r == 5'h01 && o_conv_chan == ptr_r;
  endproperty
  a_single: assert property (p_single) else $error("single start wrong");

  property p_multi_n;
    @(posedge i_core_clk) disable iff (!i_rst_n)
      s_conv_start and cfg_r[MULTI_BIT] |=> n_r == {1'b0, $past(depth)} + 5'h01 && o_conv_chan == 4'h0;
  endproperty
  a_multi_n: assert property (p_multi_n) else $error("channel count wrong");

  property p_cal;
    @(posedge i_core_clk) disable iff (!i_rst_n)
      s_cal_start |=> o_cal_go && !o_conv_go && !loop_r && !wait_r && n_r == 5'h01;
  endproperty
  a_cal: assert property (p_cal) else $error("calibration not isolated");

  property p_no_loop;
    @(posedge i_core_clk) disable iff (!i_rst_n)
      o_set_done && !loop_r |-> state_r == SQ_IDLE && !o_conv_go;
  endproperty
  a_no_loop: assert property (p_no_loop) else $error("ran past one pass");

  property p_hold_wait;
    @(posedge i_core_clk) disable iff (!i_rst_n)
      state_r == SQ_WAIT && !i_results_read |=> !o_conv_go;
  endproperty
  a_hold_wait: assert property (p_hold_wait) else $error("converted before read");

  property p_pump;
    @(posedge i_core_clk) disable iff (!i_rst_n)
      cfg_r[PUMP_DIS_BIT] |=> !o_pump_oe ##1 !o_pump_o;
  endproperty
  a_pump: assert property (p_pump) else $error("pump not floated");

  property p_sleep;
    @(posedge i_core_clk) disable iff (!i_rst_n)
      saving && cfg_r[PSS_BIT] |=> o_sleep && !o_standby && !o_osc_enable;
  endproperty
  a_sleep: assert property (p_sleep) else $error("sleep state wrong");

  property p_rv_clear;
    @(posedge i_core_clk) disable iff (!i_rst_n)
      rd_pls && !rs_fall |=> !rv_r;
  endproperty
  a_rv_clear: assert property (p_rv_clear) else $error("reset valid not cleared");

  property p_rv_set;
    @(posedge i_core_clk) disable iff (!i_rst_n)
      $fell(cfg_r[SOFT_RST_BIT]) |=> rv_r;
  endproperty
  a_rv_set: assert property (p_rv_set) else $error("reset valid not set");

endmodule // adc_cfg_core

// File: host_link.sv
`timescale 1ns/1ps
module host_link (
  // Serial link
  output logic      o_sclk,
  output logic      o_cs_n,
  output logic      o_sdi,
  input  wire logic i_sdo
);
  // ----------------
  // Frame driver
  // ----------------
  initial begin
    o_sclk = 1'b0;
    o_cs_n = 1'b1;
    o_sdi  = 1'b1;
  end

  // Clock stands still between frames; released data line flips
  task automatic frame(input logic [31:0] tx, input int nb, output logic [31:0] rx);
    rx = '0;
    #7;
    o_cs_n = 1'b0;
    for (int i = nb - 1; i >= 0; i--) begin
      o_sdi = tx[i];
      #15;
      rx = {rx[30:0], i_sdo};
      o_sclk = 1'b1;
      #15;
      o_sclk = 1'b0;
    end
    #15;
    o_cs_n = 1'b1;
    o_sdi  = ~o_sdi;
    #30;
  endtask
endmodule // host_link

// File: tb.sv
`timescale 1ns/1ps
module tb;
  import adc_cfg_pkg::*;
  // ----------------
  // Signals
  // ----------------
  logic        clk = 1'b0, rst_n = 1'b0, done = 1'b0, rres = 1'b0, stop = 1'b0, osc = 1'b0, ovr = 1'b0;
  logic        sclk, cs_n, sdi, sdo, sdo_oe, conv_go, cal_go, set_done, busy, g, gk;
  logic        standby, sleep, osc_en, low_pwr, sys_rst, pump_o, pump_oe, pb, sdo_line;
  logic [2:0]  cal_code;
  logic [3:0]  chan, p, gc;
  logic [4:0]  csr_cnt;
  logic [14:0] chop_hz;
  logic [23:0] w, r;
  logic [31:0] rx;
  int          fail_count = 0, num_checks = 0, seed = 61670, cyc = 0, oe_cnt = 0, k = 0;
  localparam int PDIV = 2;

  adc_cfg_core #(.PUMP_DIV(PDIV)) dut_u (
    .i_core_clk(clk), .i_rst_n(rst_n), .i_sclk(sclk), .i_cs_n(cs_n), .i_sdi(sdi), .o_sdo(sdo),
    .o_sdo_oe(sdo_oe), .i_conv_done(done), .i_results_read(rres), .i_stop_conv(stop),
    .o_conv_go(conv_go), .o_cal_go(cal_go), .o_cal_code(cal_code), .o_conv_chan(chan),
    .o_set_done(set_done), .o_busy(busy), .o_csr_count(csr_cnt), .i_osc_detect(osc),
    .i_overrange(ovr), .o_chop_freq_hz(chop_hz), .o_standby(standby), .o_sleep(sleep),
    .o_osc_enable(osc_en), .o_low_power(low_pwr), .o_sys_reset(sys_rst), .o_pump_o(pump_o),
    .o_pump_oe(pump_oe));
  host_link host_u (.o_sclk(sclk), .o_cs_n(cs_n), .o_sdi(sdi), .i_sdo(sdo_line));

  // Released data line shows the inverse
  assign sdo_line = sdo_oe ? sdo : ~sdo;
  // Link edges with the data line driven
  always @(posedge sclk) oe_cnt += int'(sdo_oe);

  always #5 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      end_sim();
    end
  end

  // ----------------
  // Helpers
  // ----------------
  task automatic chk(input string nm, input logic [23:0] seen, input logic [23:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("FAIL %s exp %0h seen %0h", nm, exp, seen);
    end
  endtask

  task automatic end_sim();
    $display("checks %0d failures %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  function automatic logic [14:0] chop_exp(input logic [1:0] c);
    case (c)
      2'h0: return 15'h0100;
      2'h1: return 15'h1000;
      2'h2: return 15'h4000;
      default: return 15'h0400;
    endcase
  endfunction

  task automatic wr(input logic [23:0] d);
    host_u.frame({CMD_WR_CFG, d & CFG_WR_MASK}, 32, rx);
    repeat (12) @(posedge clk);
  endtask

  // Dummy byte first so the read image is fresh
  task automatic rd(output logic [23:0] d);
    host_u.frame(32'h0, 8, rx);
    k = oe_cnt;
    host_u.frame({CMD_RD_CFG, 24'h0}, 32, rx);
    d = rx[23:0];
    chk("sdo_oe", 24'(oe_cnt - k), 24'(CFG_W));
    repeat (8) @(posedge clk);
  endtask

  task automatic pulse(input int k);
    @(posedge clk);
    done <= (k == 0);
    rres <= (k == 1);
    stop <= (k == 2);
    @(posedge clk);
    done <= 1'b0;
    rres <= 1'b0;
    stop <= 1'b0;
  endtask

  // Call at a falling edge; captures the go pulse
  task automatic wait_go();
    int n;
    n = 0;
    while (conv_go !== 1'b1 && cal_go !== 1'b1 && n < 300) begin
      @(negedge clk);
      n++;
    end
    g  = (n < 300);
    gk = cal_go;
    gc = chan;
  endtask

  task automatic run_set(input logic [7:0] cmd, input int n, input logic [3:0] ch0, input logic cal, input logic lp);
    fork
      host_u.frame({24'h0, cmd}, 8, rx);
      begin
        @(negedge clk);
        wait_go();
      end
    join
    for (int i = 0; i < n; i++) begin
      if (i > 0) wait_go();
      chk("go", 24'(g), 24'h000001);
      chk("cal_go", 24'(gk), 24'(cal));
      chk("chan", 24'(gc), 24'(ch0 + 4'(i)));
      pulse(0);
      @(negedge clk);
      chk("set_done", 24'(set_done), 24'(i == n - 1));
      chk("busy", 24'(busy), 24'(lp || i < n - 1));
    end
  endtask

  // ----------------
  // Scenarios
  // ----------------
  initial begin
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    repeat (10) @(posedge clk);
    chk("chop", 24'(chop_hz), 24'h000100);
    chk("count", 24'(csr_cnt), 24'h000001);
    rd(r);
    chk("reset word", r, CFG_RESET);
    for (int i = 0; i < 8; i++) begin
      w = 24'($random(seed));
      w[21:20] = i[1:0];
      w[7] = 1'b0;
      osc <= w[5];
      ovr <= w[4];
      wr(w);
      rd(r);
      chk("readback", r, w & (CFG_WR_MASK | 24'h000030));
      chk("chop", 24'(chop_hz), 24'(chop_exp(w[21:20])));
      chk("count", 24'(csr_cnt), 24'(w[15:12]) + 24'h000001);
      chk("pump_oe", 24'(pump_oe), 24'(!w[10]));
      if (w[10]) chk("pump_o", 24'(pump_o), 24'h000000);
      if (!w[10] && !(w[9] && w[11])) begin
        @(negedge clk);
        pb = pump_o;
        repeat (PDIV) @(negedge clk);
        chk("pump_run", 24'(pump_o), 24'(!pb));
      end
      chk("standby", 24'(standby), 24'(w[9] & !w[11]));
      chk("sleep", 24'({sleep, osc_en}), 24'({w[9] & w[11], !(w[9] & w[11])}));
      chk("low_power", 24'(low_pwr), 24'(w[8]));
    end
    osc <= 1'b0;
    ovr <= 1'b0;
    wr(24'h000080);
    chk("sys_reset", 24'(sys_rst), 24'h000001);
    wr(24'h000000);
    chk("sys_reset", 24'(sys_rst), 24'h000000);
    rd(r);
    chk("valid set", r, 24'h000040);
    rd(r);
    chk("valid clear", r, 24'h000000);
    for (int i = 0; i < 3; i++) begin
      w = (i == 0) ? 24'h000000 : (i == 1) ? 24'h00000F : 24'($random(seed) & 15);
      wr(24'h040000 | (w << DEPTH_LO));
      run_set(8'h80, int'(w) + 1, 4'h0, 1'b0, 1'b0);
    end
    p = 4'($random(seed));
    wr(24'h00F000);
    run_set({1'b1, p, 3'h0}, 1, p, 1'b0, 1'b0);
    for (int wt = 0; wt < 2; wt++) begin
      wr(wt ? 24'h071000 : 24'h020000);
      run_set({1'b1, p, 3'h0}, wt + 1, wt ? 4'h0 : p, 1'b0, 1'b1);
      if (wt == 1) begin
        repeat (20) begin
          @(negedge clk);
          chk("held", 24'(conv_go), 24'h000000);
        end
        pulse(1);
        @(negedge clk);
      end
      wait_go();
      chk("again", 24'(g), 24'h000001);
      chk("again_chan", 24'(gc), 24'(wt ? 4'h0 : p));
      pulse(2);
      repeat (3) @(negedge clk);
      chk("stopped", 24'(busy), 24'h000000);
    end
    wr(24'h075000);
    for (int c = 1; c < 8; c++) begin
      run_set({1'b1, p, 3'(c)}, 1, p, 1'b1, 1'b0);
      chk("cal_code", 24'(cal_code), 24'(c));
    end
    end_sim();
  end
endmodule // tb
